// *** core/mpsr_pkg.sv ***
/*
 * constants and types for the multiport synchronous ram port array.
 * assumes a single 200 MHz clock shared by every port and its host.
 */
// Function
// - every input except output enable and master reset is taken on the rising edge; output enable gates the data drivers with no clock.
// - a deselect or a high byte enable at an edge floats the outputs after the next edge.
// - with counter load held low and counter clear high the external address is taken on every edge, in any order.
// - on a read, a lane whose byte enable was high stays floating while the other lane drives.
// - a read inside the window after another port's write delivers one reading cycle later.
// - a read outside the window delivers the new data on its first read cycle.
// - all ports are identical; any port may write and any other read.
// - master reset clears the output flags at once, without waiting for a clock.
// - the internal address is the external one when counter load is low and counter clear is high, else the counter.
// - the drive state in each cycle follows the controls registered in the cycle before.
// - after the selects return active one selected cycle passes before outputs drive again.
package mpsr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths and counts
  localparam int DATA_W    = 18;
  localparam int LANE_W    = 9;
  localparam int LANES     = 2;
  localparam int ADDR_W    = 16;
  localparam int NUM_PORTS = 4;
  localparam int BUF_DEPTH = 2;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam real CLK_PERIOD_NS = 5.0;
  localparam real CCS_MIN_NS    = 4.5;  // clock-to-clock window
  localparam real FLAG_CLR_NS   = 6.5;  // master reset to flags clear
  localparam int  CCS_CYC       = int'($ceil(CCS_MIN_NS / CLK_PERIOD_NS));
  localparam int  LATE_EXTRA_CYC = 1;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [ADDR_W-1:0] COUNTER_RST = 16'h0000;
  localparam logic [1:0]        BUF_CNT_RST = 2'h0;

  // read delivery state of a port
  typedef enum logic {
    RD_IDLE,
    RD_LATE
  } mpsr_rd_state_t;

endpackage

// *** core/mpsr_port_array.sv ***
/*
 * several identical synchronous ram ports over one shared array, with
 * registered inputs, pipelined lane-gated read output, address counter,
 * cross-port write window delay and a two-entry read word buffer.
 * assumes the hosts drive all synchronous pins from the same clk; output
 * enable and master reset are asynchronous pins.
 */
`timescale 1ns/1ps

module mpsr_port_array
  import mpsr_pkg::*;
#(
  parameter int NumPorts = NUM_PORTS,
  parameter int AddrW    = ADDR_W
) (
  // clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  input  wire logic                           masterResetN,
  // per-port controls
  input  wire logic [NumPorts-1:0]            chipSelectLowActive,
  input  wire logic [NumPorts-1:0]            chipSelectHighActive,
  input  wire logic [NumPorts-1:0]            readNotWrite,
  input  wire logic [NumPorts-1:0]            lowerByteEnableN,
  input  wire logic [NumPorts-1:0]            upperByteEnableN,
  input  wire logic [NumPorts-1:0]            counterLoadN,
  input  wire logic [NumPorts-1:0]            counterAdvanceN,
  input  wire logic [NumPorts-1:0]            counterClearN,
  input  wire logic [NumPorts-1:0]            outputEnableN,
  // per-port address and write data
  input  wire logic [NumPorts-1:0][AddrW-1:0] address,
  input  wire logic [NumPorts-1:0][DATA_W-1:0] writeData,
  // per-port pipelined read pins
  output logic      [NumPorts-1:0][DATA_W-1:0] readDataOutput,
  output logic      [NumPorts-1:0][LANES-1:0]  readDataOe,
  output logic      [NumPorts-1:0]            wrapFlagOut,
  // per-port read word stream
  output logic      [NumPorts-1:0]            accessReady,
  output logic      [NumPorts-1:0]            wordValid,
  output logic      [NumPorts-1:0][DATA_W-1:0] wordData,
  input  wire logic [NumPorts-1:0]            wordReady
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [DATA_W-1:0] mem [1<<AddrW];

  logic mrs1_q, mrs2_q;
  logic [NumPorts-1:0]              stgAct_q, stgAct_d;
  logic [NumPorts-1:0]              stgRd_q, stgRd_d;
  logic [NumPorts-1:0][AddrW-1:0]   stgAddr_q, stgAddr_d;
  logic [NumPorts-1:0][DATA_W-1:0]  stgData_q, stgData_d;
  logic [NumPorts-1:0][LANES-1:0]   stgLane_q, stgLane_d;
  logic [NumPorts-1:0][AddrW-1:0]   cnt_q, cnt_d;
  logic [NumPorts-1:0]              wrap_q, wrap_d;
  mpsr_rd_state_t [NumPorts-1:0]    rdSt_q, rdSt_d;
  logic [NumPorts-1:0][AddrW-1:0]   lateAddr_q, lateAddr_d;
  logic [NumPorts-1:0][LANES-1:0]   lateLane_q, lateLane_d;
  logic [NumPorts-1:0][DATA_W-1:0]  dout_q, dout_d;
  logic [NumPorts-1:0][LANES-1:0]   drive_q, drive_d;
  logic [NumPorts-1:0][DATA_W-1:0]  buf0_q, buf0_d, buf1_q, buf1_d;
  logic [NumPorts-1:0][1:0]         bufCnt_q, bufCnt_d;

  // combinational helpers
  logic [NumPorts-1:0]              hazard;
  logic [NumPorts-1:0]              rdNow;
  logic [NumPorts-1:0][AddrW-1:0]   rdAddr;
  logic [NumPorts-1:0][DATA_W-1:0]  rdWord;

  ////////////////////////////////////////////////////////////////////////////
  // master reset synchroniser for internal clearing
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mrs1_q <= 1'b0;
      mrs2_q <= 1'b0;
    end else begin
      mrs1_q <= masterResetN;
      mrs2_q <= mrs1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cross-port window check and read source per port
  always_comb begin
    for (int p = 0; p < NumPorts; p++) begin
      hazard[p] = 1'b0;
      for (int j = 0; j < NumPorts; j++) begin
        if (j != p && stgAct_q[j] && !stgRd_q[j] &&
            stgAddr_q[j] == stgAddr_q[p] && CCS_CYC > 0)
          hazard[p] = stgAct_q[p] && stgRd_q[p];
      end
      rdNow[p]  = (rdSt_q[p] == RD_LATE) ||
                  (stgAct_q[p] && stgRd_q[p] && !hazard[p]);
      rdAddr[p] = (rdSt_q[p] == RD_LATE) ? lateAddr_q[p] : stgAddr_q[p];
      rdWord[p] = mem[rdAddr[p]];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next-state for every port, all ports alike
  always_comb begin
    logic                sel;
    logic [LANES-1:0]    lanes;
    logic                inflight;
    logic                push;
    logic                pop;
    sel      = 1'b0;
    lanes    = '0;
    inflight = 1'b0;
    push     = 1'b0;
    pop      = 1'b0;
    for (int p = 0; p < NumPorts; p++) begin
      sel = !chipSelectLowActive[p] && chipSelectHighActive[p];
      lanes = {!upperByteEnableN[p], !lowerByteEnableN[p]};

      // back-pressure from the word buffer onto new reads
      inflight = (stgAct_q[p] && stgRd_q[p]) || (rdSt_q[p] == RD_LATE);
      accessReady[p] = (bufCnt_q[p] == 2'h0) ||
                       (bufCnt_q[p] == 2'h1 && !inflight);

      // address counter; its next value is the access address
      wrap_d[p] = 1'b0;
      if (!counterClearN[p]) begin
        cnt_d[p] = COUNTER_RST;
      end else if (!counterLoadN[p]) begin
        cnt_d[p] = address[p];
      end else if (!counterAdvanceN[p]) begin
        cnt_d[p]  = cnt_q[p] + AddrW'(1);
        wrap_d[p] = &cnt_q[p];
      end else begin
        cnt_d[p] = cnt_q[p];
      end

      // input stage: all controls taken together on the edge
      stgAct_d[p]  = sel && (accessReady[p] || !readNotWrite[p]);
      stgRd_d[p]   = readNotWrite[p];
      stgAddr_d[p] = cnt_d[p];
      stgData_d[p] = writeData[p];
      stgLane_d[p] = lanes;

      // late delivery after a write inside the window
      rdSt_d[p]     = hazard[p] ? RD_LATE : RD_IDLE;
      lateAddr_d[p] = hazard[p] ? stgAddr_q[p] : lateAddr_q[p];
      lateLane_d[p] = hazard[p] ? stgLane_q[p] : lateLane_q[p];

      // pipelined output and its drive, set by last cycle's controls
      dout_d[p] = rdNow[p] ? rdWord[p] : dout_q[p];
      if (rdSt_q[p] == RD_LATE)
        drive_d[p] = lateLane_q[p];
      else if (rdNow[p])
        drive_d[p] = stgLane_q[p];
      else
        drive_d[p] = '0;

      // two-entry read word buffer
      push = rdNow[p];
      pop  = wordValid[p] && wordReady[p];
      buf0_d[p] = buf0_q[p];
      buf1_d[p] = buf1_q[p];
      bufCnt_d[p] = bufCnt_q[p];
      if (pop) begin
        buf0_d[p]   = buf1_q[p];
        bufCnt_d[p] = bufCnt_q[p] - 2'h1;
      end
      if (push && bufCnt_d[p] != 2'(BUF_DEPTH)) begin
        if (bufCnt_d[p] == 2'h0)
          buf0_d[p] = rdWord[p];
        else
          buf1_d[p] = rdWord[p];
        bufCnt_d[p] = bufCnt_d[p] + 2'h1;
      end

      // synchronised master reset clears port state
      if (!mrs2_q) begin
        cnt_d[p]    = COUNTER_RST;
        wrap_d[p]   = 1'b0;
        stgAct_d[p] = 1'b0;
        rdSt_d[p]   = RD_IDLE;
        drive_d[p]  = '0;
        bufCnt_d[p] = BUF_CNT_RST;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stgAct_q   <= '0;
      stgRd_q    <= '0;
      stgAddr_q  <= '0;
      stgData_q  <= '0;
      stgLane_q  <= '0;
      cnt_q      <= '0;
      wrap_q     <= '0;
      rdSt_q     <= '{default: RD_IDLE};
      lateAddr_q <= '0;
      lateLane_q <= '0;
      dout_q     <= '0;
      drive_q    <= '0;
      buf0_q     <= '0;
      buf1_q     <= '0;
      bufCnt_q   <= '0;
    end else begin
      stgAct_q   <= stgAct_d;
      stgRd_q    <= stgRd_d;
      stgAddr_q  <= stgAddr_d;
      stgData_q  <= stgData_d;
      stgLane_q  <= stgLane_d;
      cnt_q      <= cnt_d;
      wrap_q     <= wrap_d;
      rdSt_q     <= rdSt_d;
      lateAddr_q <= lateAddr_d;
      lateLane_q <= lateLane_d;
      dout_q     <= dout_d;
      drive_q    <= drive_d;
      buf0_q     <= buf0_d;
      buf1_q     <= buf1_d;
      bufCnt_q   <= bufCnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared array: lane-gated writes, port order taken as it falls
  always_ff @(posedge clk) begin
    for (int p = 0; p < NumPorts; p++) begin
      for (int l = 0; l < LANES; l++) begin
        if (stgAct_q[p] && !stgRd_q[p] && stgLane_q[p][l])
          mem[stgAddr_q[p]][l*LANE_W +: LANE_W] <=
            stgData_q[p][l*LANE_W +: LANE_W];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins: asynchronous output enable and flag clear
  always_comb begin
    for (int p = 0; p < NumPorts; p++) begin
      readDataOutput[p] = dout_q[p];
      readDataOe[p]     = drive_q[p] & {LANES{!outputEnableN[p]}};
      wrapFlagOut[p]    = wrap_q[p] && masterResetN;
      wordValid[p]      = bufCnt_q[p] != 2'h0;
      wordData[p]       = buf0_q[p];
    end
  end

endmodule // mpsr_port_array

// *** dv/mpsr_host.sv ***
/* host side sink of the read word stream.
   assumes clk is shared with the port array. */
`timescale 1ns/1ps
module mpsr_host
  import mpsr_pkg::*;
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // pacing
  input  wire logic                 stall,
  input  wire logic                 slow,
  // word stream
  output logic      [NUM_PORTS-1:0] wordReady
);
  logic [NUM_PORTS-1:0] ready_q;
  logic [NUM_PORTS-1:0] ready_d;
  // ready held off, alternating or steady
  always_comb begin
    ready_d = stall ? '0 : (slow ? ~ready_q : '1);
  end
  always_ff @(posedge clk) begin
    ready_q <= rst_n ? ready_d : '0;
  end
  assign wordReady = ready_q;
endmodule // mpsr_host

// *** dv/mpsr_port_array_asserts.sv ***
/* port 0 timing checks for the ram port array.
   assumes one shared clk and the bind below. */
`timescale 1ns/1ps
module mpsr_port_array_asserts
  import mpsr_pkg::*;
#(
  parameter int NumPorts = NUM_PORTS,
  parameter int AddrW    = ADDR_W
) (
  // clock and reset
  input wire logic                           clk,
  input wire logic                           rst_n,
  input wire logic                           masterResetN,
  // controls
  input wire logic [NumPorts-1:0]            chipSelectLowActive,
  input wire logic [NumPorts-1:0]            chipSelectHighActive,
  input wire logic [NumPorts-1:0]            readNotWrite,
  input wire logic [NumPorts-1:0]            lowerByteEnableN,
  input wire logic [NumPorts-1:0]            upperByteEnableN,
  input wire logic [NumPorts-1:0]            counterLoadN,
  input wire logic [NumPorts-1:0]            counterClearN,
  input wire logic [NumPorts-1:0]            outputEnableN,
  input wire logic [NumPorts-1:0][AddrW-1:0] address,
  // outputs watched
  input wire logic [NumPorts-1:0][LANES-1:0] readDataOe,
  input wire logic [NumPorts-1:0]            wrapFlagOut,
  input wire logic [NumPorts-1:0]            accessReady,
  input wire logic [NumPorts-1:0]            wordValid
);
  ////////////////////////////////////////////////////////////////////////////
  // accepted read on port 0, writes elsewhere, same-address write on port 1
  logic selZero;
  logic readTaken;
  logic otherWrite;
  logic sameWrite;
  assign selZero    = !chipSelectLowActive[0] && chipSelectHighActive[0];
  assign readTaken  = selZero && readNotWrite[0] && accessReady[0];
  assign otherWrite = |(~chipSelectLowActive[3:1] & chipSelectHighActive[3:1]
                        & ~readNotWrite[3:1]);
  assign sameWrite  = !chipSelectLowActive[1] && chipSelectHighActive[1]
                      && !readNotWrite[1] && address[1] == address[0]
                      && counterLoadN[1:0] == 2'h0 && counterClearN[1:0] == 2'h3;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  AST_FLAG_CLEAR: assert property (!masterResetN |-> !wrapFlagOut[0])
    else $error("wrap flag up during master reset");
  AST_OE_ASYNC: assert property (outputEnableN[0] |-> readDataOe[0] == 2'h0)
    else $error("drive while output enable off");
  AST_DESELECT: assert property (!selZero && !$past(readTaken)
    |-> ##2 readDataOe[0] == 2'h0)
    else $error("drive after deselected edge");
  AST_READ_DRIVE: assert property (readTaken && !lowerByteEnableN[0]
    && !otherWrite |-> ##2 (readDataOe[0][0] || outputEnableN[0]))
    else $error("read not driven next cycle");
  AST_UPPER_FLOAT: assert property (readTaken && upperByteEnableN[0]
    && !otherWrite && !$past(otherWrite) |-> ##2 !readDataOe[0][1])
    else $error("upper lane driven while disabled");
  AST_LOWER_FLOAT: assert property (readTaken && lowerByteEnableN[0]
    && !otherWrite && !$past(otherWrite) |-> ##2 !readDataOe[0][0])
    else $error("lower lane driven while disabled");
  AST_LATE_READ: assert property (readTaken && sameWrite && !lowerByteEnableN[0]
    |-> ##2 !readDataOe[0][0] ##1 (readDataOe[0][0] || outputEnableN[0]))
    else $error("window read not delayed one cycle");
  AST_WORD_PUSH: assert property (readTaken |-> ##[2:3] wordValid[0])
    else $error("read word not buffered");
endmodule // mpsr_port_array_asserts

bind mpsr_port_array mpsr_port_array_asserts #(
  .NumPorts(NumPorts), .AddrW(AddrW)) u_chk (.clk, .rst_n, .masterResetN,
  .chipSelectLowActive, .chipSelectHighActive, .readNotWrite,
  .lowerByteEnableN, .upperByteEnableN, .counterLoadN, .counterClearN,
  .outputEnableN, .address, .readDataOe, .wrapFlagOut, .accessReady,
  .wordValid);

// *** dv/mpsr_port_array_test.sv ***
/* self-checking bench for the ram port array.
   assumes the checker bind and the host model. */
`timescale 1ns/1ps
module mpsr_port_array_test;
  import mpsr_pkg::*;
  typedef struct packed {
    logic [1:0]  p;
    logic [1:0]  ben;
    logic [15:0] a;
    logic [17:0] d;
    logic [17:0] e;
  } mpsr_row_t;
  logic clk, rst_n, masterResetN, stall, slow;
  logic [NUM_PORTS-1:0] chipSelectLowActive, chipSelectHighActive, readNotWrite;
  logic [NUM_PORTS-1:0] lowerByteEnableN, upperByteEnableN, counterLoadN;
  logic [NUM_PORTS-1:0] counterAdvanceN, counterClearN, outputEnableN;
  logic [NUM_PORTS-1:0] wrapFlagOut, accessReady, wordValid, wordReady;
  logic [NUM_PORTS-1:0][ADDR_W-1:0] address;
  logic [NUM_PORTS-1:0][DATA_W-1:0] writeData, readDataOutput, wordData;
  logic [NUM_PORTS-1:0][LANES-1:0] readDataOe;
  int miscompares, testsRun, n;
  mpsr_row_t rows [4] = '{'{2'h0, 2'h0, 16'h0010, 18'h2A5C3, 18'h2A5C3},
    '{2'h1, 2'h2, 16'h0010, 18'h15A3C, 18'h2A43C},
    '{2'h2, 2'h1, 16'h0010, 18'h3FFFF, 18'h3FE3C},
    '{2'h3, 2'h0, 16'hFFFF, 18'h00001, 18'h00001}};
  mpsr_port_array u_dut (.clk, .rst_n, .masterResetN, .chipSelectLowActive,
    .chipSelectHighActive, .readNotWrite, .lowerByteEnableN, .upperByteEnableN,
    .counterLoadN, .counterAdvanceN, .counterClearN, .outputEnableN, .address,
    .writeData, .readDataOutput, .readDataOe, .wrapFlagOut, .accessReady,
    .wordValid, .wordData, .wordReady);
  mpsr_host u_host (.clk, .rst_n, .stall, .slow, .wordReady);
  ////////////////////////////////////////////////////////////////////////////
  // compare, verdict, one access, one read with check
  task automatic chk(input logic [17:0] s, input logic [17:0] e);
    testsRun++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %0t mismatch saw %h want %h", $time, s, e);
    end
  endtask
  task automatic summarize();
    if (miscompares == 0 && testsRun > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic acc(input int p, input logic r, input logic [15:0] a,
                     input logic [17:0] d, input logic [1:0] b, input logic h);
    @(posedge clk);
    chipSelectLowActive[p] <= 1'b0;
    chipSelectHighActive[p] <= h;
    readNotWrite[p] <= r;
    address[p] <= a;
    writeData[p] <= d;
    {upperByteEnableN[p], lowerByteEnableN[p]} <= b;
    @(posedge clk);
    chipSelectLowActive[p] <= 1'b1;
  endtask
  task automatic rd(input int p, input logic [15:0] a, input logic [1:0] b,
                    input logic h, input logic [1:0] eo, input logic [17:0] ed);
    logic [17:0] m;
    m = {{9{eo[1]}}, {9{eo[0]}}};
    acc(p, 1'b1, a, 18'h00000, b, h);
    @(posedge clk);
    #1;
    chk(readDataOe[p], eo);
    chk(readDataOutput[p] & m, ed & m);
  endtask
  task automatic wrap(input logic m, input logic e);
    @(posedge clk);
    address[0] <= 16'hFFFF;
    @(posedge clk);
    counterLoadN[0] <= 1'b1;
    counterAdvanceN[0] <= 1'b0;
    @(posedge clk);
    counterAdvanceN[0] <= 1'b1;
    counterLoadN[0] <= 1'b0;
    masterResetN <= m;
    #1;
    chk(wrapFlagOut[0], e);
    @(posedge clk);
    masterResetN <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // main sequence
  initial begin
    {chipSelectLowActive, chipSelectHighActive, readNotWrite} = '1;
    {lowerByteEnableN, upperByteEnableN, counterLoadN, outputEnableN} = '0;
    {counterAdvanceN, counterClearN} = '1;
    address = '0;
    writeData = '0;
    {rst_n, masterResetN, stall, slow} = 4'h6;
    {miscompares, testsRun} = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    stall <= 1'b0;  // host drains words so reads are not refused
    repeat (3) @(posedge clk);
    chk({wordValid, wrapFlagOut, readDataOe}, 18'h00000);
    foreach (rows[i]) begin
      acc(rows[i].p, 1'b0, rows[i].a, rows[i].d, rows[i].ben, 1'b1);
      rd((rows[i].p + 1) % 4, rows[i].a, 2'h0, 1'b1, 2'h3, rows[i].e);
    end
    rd(2, 16'h0010, 2'h0, 1'b0, 2'h0, 18'h00000);
    rd(0, 16'h0010, 2'h2, 1'b1, 2'h1, 18'h3FE3C);
    rd(0, 16'h0010, 2'h1, 1'b1, 2'h2, 18'h3FE3C);
    outputEnableN[0] <= 1'b1;
    rd(0, 16'h0010, 2'h0, 1'b1, 2'h0, 18'h00000);
    outputEnableN[0] <= 1'b0;
    @(posedge clk);
    {chipSelectLowActive[1:0], chipSelectHighActive[1:0]} <= 4'h3;
    readNotWrite[1:0] <= 2'h1;
    {upperByteEnableN[1:0], lowerByteEnableN[1:0]} <= 4'h0;
    address[1:0] <= {16'h0020, 16'h0020};
    writeData[1] <= 18'h11111;
    @(posedge clk);
    chipSelectLowActive[1:0] <= 2'h3;
    @(posedge clk);
    #1 chk(readDataOe[0], 2'h0);
    @(posedge clk);
    #1 chk(readDataOutput[0], 18'h11111);
    wrap(1'b1, 1'b1);
    wrap(1'b0, 1'b0);
    stall <= 1'b1;
    rd(3, 16'hFFFF, 2'h0, 1'b1, 2'h3, 18'h00001);
    rd(3, 16'hFFFF, 2'h0, 1'b1, 2'h3, 18'h00001);
    chk({accessReady[3], wordValid[3]}, 2'h1);
    stall <= 1'b0;
    for (n = 0; n < 10 && wordValid[3] !== 1'b0; n++) @(posedge clk);
    chk(wordValid[3], 1'b0);
    summarize();
  end
endmodule // mpsr_port_array_test
